// ==== include/floppy_pd_consts.svh ====
/*
 * Offsets, field positions, reset values and timing counts for the
 * diskette controller automatic power-down block.
 * Assumes a 200 MHz aclk and a 32-bit AXI4-Lite register bus.
 */
// Notes on behaviour
// - All timing comes from the one block clock, no second clock source.
// - Media bit rate selectable as 125, 250, 300, 500 or 1000 kbit/s.
// - Power-down command argument gives minimum powered-on time before entry.
// - Entry allowed only with motors off, interrupt low and idle high.
// - Entry happens the programmed delay after the command when conditions hold.
// - If conditions fail at timer expiry, wait and enter once they hold.
// - On entry the powered-down flag output goes high.
// - While powered down all drive interface outputs are released.
// - Idle output stays high for the whole powered-down time.
// - Oscillator enable stays on during power-down.
`ifndef FLOPPY_DOWN_CONSTS_SVH
`define FLOPPY_DOWN_CONSTS_SVH

`define REG_CTRL        8'h00
`define REG_DELAY       8'h04
`define REG_STATUS      8'h08

`define CTRL_ARM_BIT    0
`define CTRL_RATE_LSB   1
`define CTRL_RATE_MSB   3
`define RATE_RESET      3'h3
`define DOWN_DELAY_MS   500
`define DELAY_RESET     16'h01F4

`define ST_DOWN_BIT     0
`define ST_ARMED_BIT    1
`define ST_EXPIRED_BIT  2
`define ST_CRIT_BIT     3

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`define CLK_PERIOD_NS   5
`define MS_NS           1000000
`define MS_CYCLES       (`MS_NS / `CLK_PERIOD_NS)

`define RATE_125_KBPS   125
`define RATE_250_KBPS   250
`define RATE_300_KBPS   300
`define RATE_500_KBPS   500
`define RATE_1000_KBPS  1000
`define BIT_NS(k)       (1000000 / (k))
`define BIT_CYCLES(k)   ((`BIT_NS(k) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== include/floppy_pd_pkg.sv ====
/*
 * Types for the automatic power-down block.
 * Assumes nothing beyond the constants header.
 */
`default_nettype none
package floppy_down_pkg;
	typedef enum logic [1:0] {
		ST_DISARMED,
		ST_TIMING,
		ST_WAITING,
		ST_DOWN
	} down_state_t;
endpackage : floppy_down_pkg
`default_nettype wire

// ==== logic/rate_tick_gen.sv ====
/*
 * Bit-rate tick generator for the media transfer rate.
 * Assumes a 200 MHz clock and a rate select from the same domain.
 */
`include "floppy_pd_consts.svh"
`default_nettype none
module rate_tick_gen #(
	parameter int CW = 11
) (
	// Clock, reset, enable
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          ce,
	// Rate select and tick
	input  wire logic [2:0]    rate_sel,
	output logic               tick
);
	logic [CW-1:0] div;
	logic [CW-1:0] cnt_reg;

	always_comb begin
		unique case (rate_sel)
			3'h0:    div = CW'(`BIT_CYCLES(`RATE_125_KBPS));
			3'h1:    div = CW'(`BIT_CYCLES(`RATE_250_KBPS));
			3'h2:    div = CW'(`BIT_CYCLES(`RATE_300_KBPS));
			3'h4:    div = CW'(`BIT_CYCLES(`RATE_1000_KBPS));
			default: div = CW'(`BIT_CYCLES(`RATE_500_KBPS));
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= '0;
			tick    <= 1'b0;
		end else if (ce) begin
			if (cnt_reg >= div - CW'(1)) begin
				cnt_reg <= '0;
				tick    <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + CW'(1);
				tick    <= 1'b0;
			end
		end
	end
endmodule : rate_tick_gen
`default_nettype wire

// ==== logic/floppy_auto_powerdown.sv ====
/*
 * Automatic power-down control for the diskette controller, with an
 * AXI4-Lite register slave and the released drive interface.
 * Assumes motor enables, interrupt and idle come from same-clock logic.
 */
`include "floppy_pd_consts.svh"
`default_nettype none
module floppy_auto_powerdown #(
	parameter int N_MOTORS  = 4,
	parameter int DRIVE_W   = 8,
	parameter int MS_CYCLES = `MS_CYCLES
) (
	// Clock, reset, enable
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                ce,
	// AXI4-Lite write address
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Controller status
	input  wire logic [N_MOTORS-1:0] motor_en,
	input  wire logic                int_level,
	input  wire logic                idle_level,
	input  wire logic [DRIVE_W-1:0]  drive_data,
	// Drive interface and indicators
	output logic [DRIVE_W-1:0]       drive_out,
	output logic [DRIVE_W-1:0]       drive_oe_n,
	output logic                     powered_down_flag,
	output logic                     idle_out,
	output logic                     osc_enable,
	output logic                     rate_tick
);
	localparam int CW = $clog2(MS_CYCLES);

	floppy_down_pkg::down_state_t state_reg;
	floppy_down_pkg::down_state_t state_next;

	logic [7:0]    awaddr_reg;
	logic [31:0]   wdata_reg;
	logic [3:0]    wstrb_reg;
	logic          aw_hold_reg;
	logic          w_hold_reg;
	logic [2:0]    rate_reg;
	logic [15:0]   delay_reg;
	logic [CW-1:0] cyc_reg;
	logic [15:0]   ms_reg;
	logic          do_write;
	logic          arm_cmd;
	logic          disarm_cmd;
	logic          bus_access;
	logic          crit;
	logic          wake;
	logic          expired;
	logic          restart;
	logic          ms_tick;
	logic [31:0]   status_word;

	// Bus handshakes
	assign do_write   = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign bus_access = (s_axi_awvalid && s_axi_awready)
	                  || (s_axi_arvalid && s_axi_arready);
	assign arm_cmd    = do_write && awaddr_reg == `REG_CTRL
	                  && wstrb_reg[0] && wdata_reg[`CTRL_ARM_BIT];
	assign disarm_cmd = do_write && awaddr_reg == `REG_CTRL
	                  && wstrb_reg[0] && !wdata_reg[`CTRL_ARM_BIT];

	assign crit    = !(|motor_en) && !int_level && idle_level;
	assign wake    = bus_access || (|motor_en);
	assign expired = ms_reg >= delay_reg;
	assign restart = bus_access
	               || (state_reg == floppy_down_pkg::ST_DOWN && wake);
	// millisecond base from the block clock
	assign ms_tick = cyc_reg == CW'(MS_CYCLES - 1);

	assign status_word = {28'h0000000, crit, expired,
	                      state_reg != floppy_down_pkg::ST_DISARMED,
	                      state_reg == floppy_down_pkg::ST_DOWN};

	// Write address and data capture, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			aw_hold_reg   <= 1'b0;
			awaddr_reg    <= 8'h00;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_hold_reg   <= 1'b1;
				awaddr_reg    <= s_axi_awaddr;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
			end
			if (do_write) begin
				aw_hold_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			w_hold_reg   <= 1'b0;
			wdata_reg    <= 32'h00000000;
			wstrb_reg    <= 4'h0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_hold_reg   <= 1'b1;
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_wready <= 1'b1;
			end
			if (do_write) begin
				w_hold_reg <= 1'b0;
			end
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				if (awaddr_reg == `REG_CTRL || awaddr_reg == `REG_DELAY
				    || awaddr_reg == `REG_STATUS) begin
					s_axi_bresp <= `RESP_OKAY;
				end else begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rate_reg  <= `RATE_RESET;
			delay_reg <= `DELAY_RESET;
		end else if (ce && do_write) begin
			if (awaddr_reg == `REG_CTRL && wstrb_reg[0]) begin
				rate_reg <= wdata_reg[`CTRL_RATE_MSB:`CTRL_RATE_LSB];
			end
			if (awaddr_reg == `REG_DELAY) begin
				if (wstrb_reg[0]) begin
					delay_reg[7:0] <= wdata_reg[7:0];
				end
				if (wstrb_reg[1]) begin
					delay_reg[15:8] <= wdata_reg[15:8];
				end
			end
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `RESP_OKAY;
				unique case (s_axi_araddr)
					`REG_CTRL: begin
						s_axi_rdata <= {28'h0000000, rate_reg,
						                state_reg != floppy_down_pkg::ST_DISARMED};
					end
					`REG_DELAY: begin
						s_axi_rdata <= {16'h0000, delay_reg};
					end
					`REG_STATUS: begin
						s_axi_rdata <= status_word;
					end
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_reg <= '0;
			ms_reg  <= 16'h0000;
		end else if (ce) begin
			if (state_reg == floppy_down_pkg::ST_DISARMED || restart
			    || arm_cmd) begin
				cyc_reg <= '0;
				ms_reg  <= 16'h0000;
			end else if (ms_tick) begin
				cyc_reg <= '0;
				if (ms_reg != 16'hFFFF) begin
					ms_reg <= ms_reg + 16'h0001;
				end
			end else begin
				cyc_reg <= cyc_reg + CW'(1);
			end
		end
	end

	// Power-down sequencing
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			floppy_down_pkg::ST_DISARMED: begin
				if (arm_cmd) begin
					state_next = floppy_down_pkg::ST_TIMING;
				end
			end
			floppy_down_pkg::ST_TIMING: begin
				if (disarm_cmd) begin
					state_next = floppy_down_pkg::ST_DISARMED;
				end else if (!restart && !arm_cmd && expired) begin
					state_next = crit ? floppy_down_pkg::ST_DOWN
					                  : floppy_down_pkg::ST_WAITING;
				end
			end
			floppy_down_pkg::ST_WAITING: begin
				if (disarm_cmd) begin
					state_next = floppy_down_pkg::ST_DISARMED;
				end else if (bus_access || arm_cmd) begin
					state_next = floppy_down_pkg::ST_TIMING;
				end else if (crit) begin
					state_next = floppy_down_pkg::ST_DOWN;
				end
			end
			floppy_down_pkg::ST_DOWN: begin
				if (wake) begin
					state_next = floppy_down_pkg::ST_TIMING;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= floppy_down_pkg::ST_DISARMED;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			powered_down_flag <= 1'b0;
			drive_out         <= '0;
			drive_oe_n        <= '0;
			idle_out          <= 1'b0;
		end else if (ce) begin
			powered_down_flag <= state_next == floppy_down_pkg::ST_DOWN;
			drive_out         <= drive_data;
			drive_oe_n        <=
				{DRIVE_W{state_next == floppy_down_pkg::ST_DOWN}};
			idle_out <= idle_level || state_next == floppy_down_pkg::ST_DOWN;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_enable <= 1'b1;
		end else if (ce) begin
			osc_enable <= 1'b1;
		end
	end

	rate_tick_gen #(
		.CW       (11)
	) u_rate (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ce       (ce),
		.rate_sel (rate_reg),
		.tick     (rate_tick)
	);

	down_entry_a : assert property (@(posedge aclk) disable iff (!aresetn)
		($rose(powered_down_flag) && $past(ce)) |-> $past(crit))
		else $error("power-down entered without entry conditions");
	down_flag_a : assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == floppy_down_pkg::ST_DOWN) == powered_down_flag)
		else $error("flag does not follow power-down state");
	tristate_a : assert property (@(posedge aclk) disable iff (!aresetn)
		powered_down_flag |-> (&drive_oe_n))
		else $error("drive outputs driven while powered down");
	idle_high_a : assert property (@(posedge aclk) disable iff (!aresetn)
		powered_down_flag |-> idle_out)
		else $error("idle low while powered down");
	osc_run_a : assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) |-> osc_enable)
		else $error("oscillator disabled");
	wake_exit_a : assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && powered_down_flag && (|motor_en)) |=> !powered_down_flag)
		else $error("no wake on motor enable");
	defer_entry_a : assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && state_reg == floppy_down_pkg::ST_WAITING && crit
		 && !bus_access && !arm_cmd && !disarm_cmd) |=> powered_down_flag)
		else $error("deferred entry missed");
	min_time_a : assert property (@(posedge aclk) disable iff (!aresetn)
		($rose(powered_down_flag) && $past(ce))
		|-> $past(ms_reg) >= $past(delay_reg))
		else $error("power-down before delay elapsed");
	rate_gap_a : assert property (@(posedge aclk) disable iff (!aresetn)
		(rate_tick && ce) |=> (!rate_tick)[*8])
		else $error("rate ticks too close");
endmodule : floppy_auto_powerdown
`default_nettype wire

// ==== dv/ctrl_status_model.sv ====
/*
 * Behavioural model of the controller core beside the power-down block.
 * Assumes the bench requests motor and busy states on aclk.
 */
`default_nettype none
module ctrl_status_model (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Requests from the bench
	input  wire logic [3:0] motor_req,
	input  wire logic       busy_req,
	// Status toward the block
	output logic [3:0]      motor_en,
	output logic            int_level,
	output logic            idle_level,
	output logic [7:0]      drive_data
);
	timeunit 1ns;
	timeprecision 100ps;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			motor_en   <= 4'h0;
			int_level  <= 1'b0;
			idle_level <= 1'b1;
		end else begin
			motor_en   <= motor_req;
			int_level  <= busy_req;
			idle_level <= !busy_req && (motor_req == 4'h0);
		end
	end
	// Drive pattern flips every cycle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			drive_data <= 8'h5A;
		else
			drive_data <= ~drive_data;
	end
endmodule : ctrl_status_model
`default_nettype wire

// ==== dv/test_floppy_auto_powerdown.sv ====
/*
 * Bench for the automatic power-down block over AXI4-Lite.
 * Assumes the constants header and a shortened millisecond count.
 */
`include "floppy_pd_consts.svh"
`default_nettype none
module test_floppy_auto_powerdown;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int MSC = 4;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, busy_req, ce;
	logic        int_level, idle_level, flag, idle_out, osc_enable, rate_tick;
	logic [7:0]  awaddr, araddr, drive_data, drive_out, drive_oe_n;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, rs;
	logic [3:0]  motor_req, motor_en;
	int          num_errors = 0, cmp_count = 0, n, i;
	int          per[6] = '{1600, 800, 667, 400, 200, 400};

	floppy_auto_powerdown #(.MS_CYCLES(MSC)) dut (.aclk(aclk),
		.aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .motor_en(motor_en), .int_level(int_level),
		.idle_level(idle_level), .drive_data(drive_data),
		.drive_out(drive_out), .drive_oe_n(drive_oe_n),
		.powered_down_flag(flag), .idle_out(idle_out),
		.osc_enable(osc_enable), .rate_tick(rate_tick));
	ctrl_status_model partner (.aclk(aclk), .aresetn(aresetn),
		.motor_req(motor_req), .busy_req(busy_req), .motor_en(motor_en),
		.int_level(int_level), .idle_level(idle_level),
		.drive_data(drive_data));

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic complete_run;
		$display("Mismatches %0d, comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	task automatic hang;
		num_errors++;
		$display("[FAIL] t=%0t wait ran out", $time);
		complete_run();
	endtask : hang

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int k;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
		end
		if (k == 50) hang();
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int k;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
		end
		if (k == 50) hang();
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rdr

	task automatic wait_flag(input logic v, output int c);
		for (c = 0; c < 200; c++) begin
			@(posedge aclk);
			if (flag === v) break;
		end
		if (c == 200) hang();
	endtask : wait_flag

	task automatic tick_period(output int p);
		int k;
		for (k = 0; k < 3; k++) begin
			p = 0;
			do begin
				@(posedge aclk);
				p++;
			end while (rate_tick !== 1'b1 && p < 2000);
		end
		if (p >= 2000) hang();
	endtask : tick_period

	// Hold entry off with a busy source, then release it
	task automatic defer_entry;
		repeat (30) @(posedge aclk);
		chk(flag, 1'b0);
		motor_req <= 4'h0;
		busy_req <= 1'b0;
		wait_flag(1'b1, n);
		chk(n <= 4, 1'b1);
	endtask : defer_entry

	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, busy_req} = 6'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		motor_req = 4'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(`REG_CTRL, rd, rs);
		chk(rd, {28'h0, `RATE_RESET, 1'b0});
		rdr(`REG_DELAY, rd, rs);
		chk(rd, {16'h0, `DELAY_RESET});
		rdr(`REG_STATUS, rd, rs);
		chk(rd, 32'h00000008);
		chk(osc_enable, 1'b1);
		rdr(8'h0C, rd, rs);
		chk({rs, rd}, {`RESP_SLVERR, 32'h0});
		wr(8'h0C, 32'h1, rs);
		chk(rs, `RESP_SLVERR);
		wr(`REG_STATUS, 32'hF, rs);
		rdr(`REG_STATUS, rd, rs);
		chk({rs, rd}, {`RESP_OKAY, 32'h00000008});
		for (i = 0; i < 6; i++) begin
			wr(`REG_CTRL, i << 1, rs);
			tick_period(n);
			chk(n, per[i]);
		end
		wr(`REG_DELAY, 32'h2, rs);
		wr(`REG_CTRL, 32'h7, rs);
		wait_flag(1'b1, n);
		chk(n inside {[4:12]}, 1'b1);
		chk({drive_oe_n, idle_out}, {8'hFF, 1'b1});
		repeat (6) @(posedge aclk);
		chk({flag, idle_out, osc_enable}, 3'h7);
		// Frozen by the clock enable, the wake must wait
		ce <= 1'b0;
		motor_req <= 4'h1;
		repeat (5) @(posedge aclk);
		chk({flag, drive_oe_n}, 9'h1FF);
		ce <= 1'b1;
		wait_flag(1'b0, n);
		chk(n <= 4, 1'b1);
		@(posedge aclk);
		chk({drive_oe_n, drive_out}, {8'h00, ~drive_data});
		defer_entry();
		rdr(`REG_STATUS, rd, rs);
		chk({rs, rd}, {`RESP_OKAY, 32'h0000000F});
		@(posedge aclk);
		chk({flag, drive_oe_n}, 9'h000);
		busy_req <= 1'b1;
		defer_entry();
		chk(osc_enable, 1'b1);
		complete_run();
	end
endmodule : test_floppy_auto_powerdown
`default_nettype wire
